// ===== deac_arr_if.sv
// Interface: request and answer signals between the controller and its array
`timescale 1ns/1ps
interface deac_arr_if #(parameter int AW = 8);
	logic [AW-1:0] addr;
	logic [7:0] wdata;
	logic we;
	logic [7:0] rdata;
	modport ctrl (output addr, output wdata, output we, input rdata);
	modport arr (input addr, input wdata, input we, output rdata);
endinterface : deac_arr_if

// ===== deac_array.sv
// Module: flip-flop data array, one byte per address
`timescale 1ns/1ps
module deac_array #(
	parameter int AW = 8
) (
	// Clock
	input wire logic clk,
	// Port to the controller
	deac_arr_if.arr port
);
	localparam int DEPTH = 1 << AW;
	logic [7:0] mem_ff [DEPTH];

	////////////////////////////////////////////////////////////////////////
	// Cells keep their contents across a reset, as a real array would
	always_ff @(posedge clk) begin
		if (port.we) begin
			mem_ff[port.addr] <= port.wdata;
		end
	end

	// Asynchronous read so the controller can latch in one cycle
	assign port.rdata = mem_ff[port.addr];
endmodule : deac_array

// ===== deac_ctrl.sv
// Module: data array access controller with unlock, write timing and guard
// What this block does
// - Read strobe with memory select clear loads addressed byte next cycle.
// - Data register holds the read byte until next read or software write.
// - Write starts only after 55h then AAh to key port, then write strobe.
// - Write strobe cannot be set unless write permit is already set.
// - Permit and strobe set in one bus write never start a write.
// - Hardware never clears write permit; only software or any reset.
// - During a write, control, address and data writes are ignored.
// - Write end clears the write strobe and sets write-done flag.
// - Write-done flag stays set until software clears it.
// - Code protect blocks all external array reads and writes.
// - Internal processor access works whatever the code protect bit.
// - Power-up clears write permit.
// - No array write while the power-up timer runs.
// - Key port stores nothing; writes only feed the unlock detector.
// - Unimplemented bits read as zero, control bit 5 included.
// - Abort flag set on reset mid-write or improper write attempt.
//
// Our own choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
module deac_ctrl #(
	parameter int AW = 8,
	parameter int PWRT_CYCLES = deac_pkg::PWRT_CYC,
	parameter int WRITE_CYCLES = deac_pkg::WRITE_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [4:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// External programming port and code protect strap
	input wire logic code_protect,
	input wire logic ext_req,
	input wire logic ext_we,
	input wire logic [AW-1:0] ext_addr,
	input wire logic [7:0] ext_wdata,
	output logic [7:0] ext_rdata,
	output logic ext_ack,
	// Interrupt request towards the core
	output logic write_done_irq
);
	deac_arr_if #(.AW(AW)) arr_bus ();

	deac_array #(.AW(AW)) deac_array_inst (
		.clk(clk),
		.port(arr_bus)
	);

	localparam int PW = $clog2(PWRT_CYCLES + 1);
	localparam int WW = $clog2(WRITE_CYCLES + 1);

	logic [7:0] addr_ff;
	logic [7:0] data_ff;
	logic mem_sel_ff;
	logic cfg_sel_ff;
	logic abort_ff;
	logic permit_ff;
	logic wr_ff;
	logic done_flag_ff;
	logic done_en_ff;
	logic done_prio_ff;
	logic [7:0] flags_other_ff;
	logic [7:0] en_other_ff;
	logic [7:0] prio_other_ff;
	logic [PW-1:0] pwrt_cnt_ff;
	logic [WW-1:0] wcnt_ff;
	logic pwrt_done_ff;
	logic first_ff;
	deac_pkg::deac_key_t key_ff;
	deac_pkg::deac_key_t nxt_key;
	logic [2:0] cp_sync_ff;
	logic cp_ff;

	// Bus strobes: a new request is one not yet acknowledged
	logic req;
	logic wr_req;
	logic rd_req;
	logic lane0;
	logic [7:0] wbyte;
	logic busy;
	logic wr_start;
	logic write_end;
	logic ext_ok;

	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign lane0 = wb_sel_i[0];
	assign wr_req = req && wb_we_i && lane0;
	assign rd_req = req && !wb_we_i;
	assign wbyte = wb_dat_i[7:0];
	assign busy = wr_ff;
	// Permit must already be stored: the bus write itself cannot grant it
	assign wr_start = wr_req && wb_adr_i == deac_pkg::OFF_CTRL && !busy
		&& wbyte[deac_pkg::CTRL_WR] && permit_ff
		&& key_ff == deac_pkg::KEY_ARMED && pwrt_done_ff
		&& !wbyte[deac_pkg::CTRL_MEMSEL];
	assign write_end = busy && wcnt_ff == WW'(1);

	////////////////////////////////////////////////////////////////////////
	// Wishbone ack: one cycle answer, dropped the cycle after
	always_ff @(posedge clk) begin
		if (srst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req;
		end
	end

	// Read data mux; unimplemented bits and unmapped offsets read zero
	always_ff @(posedge clk) begin
		if (srst) begin
			wb_dat_o <= 32'h0;
		end else if (rd_req) begin
			wb_dat_o <= 32'h0;
			case (wb_adr_i)
			deac_pkg::OFF_ADDR: wb_dat_o[7:0] <= addr_ff;
			deac_pkg::OFF_DATA: wb_dat_o[7:0] <= data_ff;
			deac_pkg::OFF_CTRL: wb_dat_o[7:0] <= {mem_sel_ff, cfg_sel_ff,
				2'b00, abort_ff, permit_ff, wr_ff, 1'b0};
			deac_pkg::OFF_FLAGS: wb_dat_o[7:0] <= (flags_other_ff
				| (8'(done_flag_ff) << deac_pkg::FLAG_DONE))
				& deac_pkg::PERIPH_MASK;
			deac_pkg::OFF_ENABLES: wb_dat_o[7:0] <= (en_other_ff
				| (8'(done_en_ff) << deac_pkg::FLAG_DONE))
				& deac_pkg::PERIPH_MASK;
			deac_pkg::OFF_PRIO: wb_dat_o[7:0] <= (prio_other_ff
				| (8'(done_prio_ff) << deac_pkg::FLAG_DONE))
				& deac_pkg::PERIPH_MASK;
			deac_pkg::OFF_STATUS: wb_dat_o[7:0] <= {6'h00, cp_ff,
				pwrt_done_ff};
			default: wb_dat_o <= 32'h0; // Key port reads zero
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Power-up timer: array writes blocked until it expires
	always_ff @(posedge clk) begin
		if (srst) begin
			pwrt_cnt_ff <= '0;
			pwrt_done_ff <= 1'b0;
		end else if (!pwrt_done_ff) begin
			pwrt_cnt_ff <= pwrt_cnt_ff + PW'(1);
			pwrt_done_ff <= pwrt_cnt_ff == PW'(PWRT_CYCLES - 1);
		end
	end

	// Address register, frozen during a write
	always_ff @(posedge clk) begin
		if (srst) begin
			addr_ff <= deac_pkg::RST_BYTE;
		end else if (wr_req && wb_adr_i == deac_pkg::OFF_ADDR && !busy) begin
			addr_ff <= wbyte;
		end
	end

	// Data register: loaded by software or by a read strobe
	always_ff @(posedge clk) begin
		if (srst) begin
			data_ff <= deac_pkg::RST_BYTE;
		end else if (wr_req && !busy && wb_adr_i == deac_pkg::OFF_CTRL
			&& wbyte[deac_pkg::CTRL_RD] && !wbyte[deac_pkg::CTRL_MEMSEL]) begin
			data_ff <= arr_bus.rdata;
		end else if (wr_req && wb_adr_i == deac_pkg::OFF_DATA && !busy) begin
			data_ff <= wbyte;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Unlock detector; any other bus write breaks the sequence
	always_comb begin
		nxt_key = key_ff;
		if (wr_req && !busy) begin
			if (wb_adr_i == deac_pkg::OFF_KEY) begin
				if (wbyte == deac_pkg::KEY_FIRST) begin
					nxt_key = deac_pkg::KEY_GOT_FIRST;
				end else if (wbyte == deac_pkg::KEY_SECOND
					&& key_ff == deac_pkg::KEY_GOT_FIRST) begin
					nxt_key = deac_pkg::KEY_ARMED;
				end else begin
					nxt_key = deac_pkg::KEY_IDLE;
				end
			end else begin
				nxt_key = deac_pkg::KEY_IDLE;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			key_ff <= deac_pkg::KEY_IDLE;
		end else begin
			key_ff <= nxt_key;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control register; permit only ever changed by software or reset
	always_ff @(posedge clk) begin
		if (srst) begin
			mem_sel_ff <= 1'b0;
			cfg_sel_ff <= 1'b0;
			permit_ff <= 1'b0;
		end else if (wr_req && wb_adr_i == deac_pkg::OFF_CTRL && !busy) begin
			mem_sel_ff <= wbyte[deac_pkg::CTRL_MEMSEL];
			cfg_sel_ff <= wbyte[deac_pkg::CTRL_CFGSEL];
			permit_ff <= wbyte[deac_pkg::CTRL_PERMIT];
		end
	end

	// Write strobe and self-timed write counter; the count survives a reset
	// so that a write cut short by it can still be seen afterwards
	always_ff @(posedge clk) begin
		if (srst) begin
			wr_ff <= 1'b0;
		end else if (first_ff) begin
			wcnt_ff <= '0; // Left count noted once by the abort flag
		end else if (wr_start) begin
			wr_ff <= 1'b1;
			wcnt_ff <= WW'(WRITE_CYCLES);
		end else if (busy) begin
			wcnt_ff <= wcnt_ff - WW'(1);
			if (write_end) begin
				wr_ff <= 1'b0;
			end
		end
	end

	// Abort flag: first cycle after reset notes a write cut short
	always_ff @(posedge clk) begin
		if (srst) begin
			first_ff <= 1'b1;
		end else begin
			first_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			abort_ff <= 1'b0;
		end else if (first_ff && wcnt_ff != '0) begin
			abort_ff <= 1'b1;
		end else if (wr_req && wb_adr_i == deac_pkg::OFF_CTRL && !busy
			&& wbyte[deac_pkg::CTRL_WR] && !wr_start) begin
			abort_ff <= 1'b1;
		end else if (wr_start) begin
			abort_ff <= 1'b0;
		end else if (wr_req && wb_adr_i == deac_pkg::OFF_CTRL && !busy) begin
			abort_ff <= wbyte[deac_pkg::CTRL_ABORT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Write-done flag: hardware set wins over a software clear
	always_ff @(posedge clk) begin
		if (srst) begin
			done_flag_ff <= 1'b0;
		end else if (write_end) begin
			done_flag_ff <= 1'b1;
		end else if (wr_req && wb_adr_i == deac_pkg::OFF_FLAGS) begin
			done_flag_ff <= wbyte[deac_pkg::FLAG_DONE];
		end
	end

	// Other peripheral flag, enable and priority bits are plain storage
	always_ff @(posedge clk) begin
		if (srst) begin
			flags_other_ff <= deac_pkg::RST_BYTE;
			en_other_ff <= deac_pkg::RST_BYTE;
			prio_other_ff <= deac_pkg::RST_BYTE;
			done_en_ff <= 1'b0;
			done_prio_ff <= 1'b0;
		end else if (wr_req) begin
			case (wb_adr_i)
			deac_pkg::OFF_FLAGS: flags_other_ff <= wbyte & 8'hCF;
			deac_pkg::OFF_ENABLES: begin
				en_other_ff <= wbyte & 8'hCF;
				done_en_ff <= wbyte[deac_pkg::FLAG_DONE];
			end
			deac_pkg::OFF_PRIO: begin
				prio_other_ff <= wbyte & 8'hCF;
				done_prio_ff <= wbyte[deac_pkg::FLAG_DONE];
			end
			default: ;
			endcase
		end
	end

	// Interrupt line from flag and its enable
	always_ff @(posedge clk) begin
		if (srst) begin
			write_done_irq <= 1'b0;
		end else begin
			write_done_irq <= done_flag_ff && done_en_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Code protect strap synchroniser, three stages
	always_ff @(posedge clk) begin
		if (srst) begin
			cp_sync_ff <= 3'b111;
			cp_ff <= 1'b1;
		end else begin
			cp_sync_ff <= {cp_sync_ff[1:0], code_protect};
			if (cp_sync_ff[1] == cp_sync_ff[2]) begin
				cp_ff <= cp_sync_ff[2];
			end
		end
	end

	// External port served only when idle, never while protected
	assign ext_ok = ext_req && !cp_ff && !busy && !ext_ack;

	always_ff @(posedge clk) begin
		if (srst) begin
			ext_ack <= 1'b0;
			ext_rdata <= 8'h00;
		end else begin
			ext_ack <= ext_req && !busy && !ext_ack;
			if (ext_ok && !ext_we) begin
				ext_rdata <= arr_bus.rdata;
			end else if (ext_req && cp_ff) begin
				ext_rdata <= 8'h00;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Array port: internal write on last cycle, else external access
	always_comb begin
		arr_bus.addr = AW'(addr_ff);
		arr_bus.wdata = data_ff;
		arr_bus.we = 1'b0;
		if (write_end) begin
			arr_bus.we = pwrt_done_ff;
		end else if (ext_ok) begin
			arr_bus.addr = ext_addr;
			arr_bus.wdata = ext_wdata;
			arr_bus.we = ext_we && pwrt_done_ff;
		end
	end
endmodule : deac_ctrl

// ===== deac_ctrl_props.sv
// Checker: port-level properties of the data array access controller
`timescale 1ns/1ps
module deac_ctrl_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// External port and interrupt
	input wire logic code_protect,
	input wire logic ext_req,
	input wire logic [7:0] ext_rdata,
	input wire logic ext_ack,
	input wire logic write_done_irq
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	////////////////////////////////////////////////////////////////////////
	// A request that has not been answered yet
	sequence req_taken;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	// Strap held long enough to pass the three-stage synchroniser
	sequence prot_held;
		code_protect [*7];
	endsequence
	// No software write this cycle; a write to the flag or enable register may legally clear them
	sequence no_write;
		!(wb_cyc_i && wb_stb_i && wb_we_i);
	endsequence
	////////////////////////////////////////////////////////////////////////
	ack_answer_a: assert property (req_taken |=> wb_ack_o)
		else $error("bus request not answered in one cycle");
	ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus acknowledge longer than one cycle");
	ack_cause_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("bus acknowledge without a request");
	read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
		else $error("unused read data bits not zero");
	ext_block_a: assert property (prot_held ##0 ext_ack |-> ext_rdata == 8'h00)
		else $error("protected external read returned data");
	ext_cause_a: assert property (!ext_req |=> !ext_ack)
		else $error("external acknowledge without a request");
	irq_hold_a: assert property (write_done_irq ##0 no_write |=> write_done_irq)
		else $error("write done interrupt dropped by itself");
	reset_quiet_a: assert property ($fell(srst) |-> !wb_ack_o && !write_done_irq && !ext_ack)
		else $error("outputs active right after reset");
endmodule : deac_ctrl_chk

bind deac_ctrl deac_ctrl_chk deac_ctrl_chk_inst (.clk(clk), .srst(srst),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .code_protect(code_protect),
	.ext_req(ext_req), .ext_rdata(ext_rdata), .ext_ack(ext_ack),
	.write_done_irq(write_done_irq));

// ===== deac_pkg.sv
// Package: register map, control bit layout and timing constants for deac
package deac_pkg;
	// Register word offsets on the Wishbone bus (byte addresses)
	localparam logic [4:0] OFF_ADDR = 5'h00;
	localparam logic [4:0] OFF_DATA = 5'h04;
	localparam logic [4:0] OFF_CTRL = 5'h08;
	localparam logic [4:0] OFF_KEY = 5'h0C;
	localparam logic [4:0] OFF_FLAGS = 5'h10;
	localparam logic [4:0] OFF_ENABLES = 5'h14;
	localparam logic [4:0] OFF_PRIO = 5'h18;
	localparam logic [4:0] OFF_STATUS = 5'h1C;
	// Control register bit positions
	localparam int CTRL_MEMSEL = 7;
	localparam int CTRL_CFGSEL = 6;
	localparam int CTRL_ABORT = 3;
	localparam int CTRL_PERMIT = 2;
	localparam int CTRL_WR = 1;
	localparam int CTRL_RD = 0;
	// Flag, enable and priority registers: write-done bit position
	localparam int FLAG_DONE = 4;
	// Writable bits of control, flag and enable registers
	localparam logic [7:0] CTRL_WMASK = 8'hCD;
	localparam logic [7:0] PERIPH_MASK = 8'hDF;
	// Unlock keys
	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'hAA;
	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	// Clock and timing
	localparam int CLK_HZ = 25000000;
	localparam int PWRT_US = 65536;
	localparam int PWRT_CYC = (PWRT_US / 1000) * (CLK_HZ / 1000);
	localparam int WRITE_US = 4;
	localparam int WRITE_CYC = (WRITE_US * (CLK_HZ / 1000000));
	// Unlock sequence states
	typedef enum logic [1:0] {
		KEY_IDLE,
		KEY_GOT_FIRST,
		KEY_ARMED
	} deac_key_t;
endpackage : deac_pkg

// ===== test_data_eeprom_access_ctrl.sv
// Testbench: self-checking run of the data array access controller
`timescale 1ns/1ps
module test_data_eeprom_access_ctrl;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [4:0] wb_adr_i = 5'h00;
	logic [3:0] wb_sel_i = 4'h1;
	logic [31:0] wb_dat_i = 32'h00000000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic code_protect = 1'b0;
	logic ext_req = 1'b0;
	logic ext_we = 1'b0;
	logic [7:0] ext_addr = 8'h00;
	logic [7:0] ext_wdata = 8'h00;
	logic [7:0] ext_rdata;
	logic ext_ack;
	logic write_done_irq;
	int miscompares = 0;
	int n_tests = 0;
	logic [7:0] rd, a, d;
	// Broken start sequences: keys, stray write, control value
	logic [7:0] bk1 [5] = '{8'hAA, 8'h55, 8'h55, 8'h55, 8'h55};
	logic [7:0] bk2 [5] = '{8'h55, 8'h55, 8'hAB, 8'hAA, 8'hAA};
	logic bmid [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
	logic [7:0] bpre [5] = '{8'h04, 8'h04, 8'h04, 8'h04, 8'h00};

	// Short counts keep the run brief; busy outlasts three bus writes
	deac_ctrl #(.PWRT_CYCLES(24), .WRITE_CYCLES(16)) deac_ctrl_inst (.clk,
		.srst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .code_protect, .ext_req, .ext_we,
		.ext_addr, .ext_wdata, .ext_rdata, .ext_ack, .write_done_irq);

	// 25 MHz clock
	initial begin
		forever #20 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task automatic complete_run();
		if (miscompares == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : complete_run
	// Compare seen against expected, four-state
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Expected control byte from its flag bits at the package's positions
	function automatic logic [7:0] ctrl_exp(input logic ab, pm, ws);
		ctrl_exp = 8'h00;
		ctrl_exp[deac_pkg::CTRL_ABORT] = ab;
		ctrl_exp[deac_pkg::CTRL_PERMIT] = pm;
		ctrl_exp[deac_pkg::CTRL_WR] = ws;
	endfunction : ctrl_exp
	// One classic cycle; held until ack is sampled
	task automatic wb(input logic we, input logic [4:0] ad, input logic [7:0] v);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= ad;
		wb_dat_i <= {24'h000000, v};
		do @(posedge clk); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk);
	endtask : wb
	task automatic wr(input logic [4:0] ad, input logic [7:0] v);
		wb(1'b1, ad, v);
	endtask : wr
	task automatic rdc(input logic [4:0] ad, input logic [7:0] exp);
		wb(1'b0, ad, 8'h00);
		check(rd, exp);
	endtask : rdc
	// Keys, an optional stray write between them, then the control write
	task automatic try_start(input logic [7:0] k1, k2, input logic mid,
		input logic [7:0] c);
		wr(deac_pkg::OFF_KEY, k1); // Wrong keys or mid break it
		if (mid) begin
			wr(deac_pkg::OFF_ADDR, a);
		end
		wr(deac_pkg::OFF_KEY, k2);
		wr(deac_pkg::OFF_CTRL, c);
	endtask : try_start
	// Array read through address and read strobe
	task automatic rd_byte(input logic [7:0] ad);
		wr(deac_pkg::OFF_ADDR, ad);
		wr(deac_pkg::OFF_CTRL, 8'h01);
	endtask : rd_byte
	// Poll the strobe bit, bounded
	task automatic wait_idle();
		for (int i = 0; i < 20; i++) begin
			wb(1'b0, deac_pkg::OFF_CTRL, 8'h00);
			if (rd[1] === 1'b0) begin
				break;
			end
		end
	endtask : wait_idle
	// External programming access; read data taken at the ack edge
	task automatic ext(input logic we, input logic [7:0] ad, wd, exp);
		ext_req <= 1'b1;
		ext_we <= we;
		ext_addr <= ad;
		ext_wdata <= wd;
		do @(posedge clk); while (ext_ack !== 1'b1);
		ext_req <= 1'b0;
		if (!we) begin
			check(ext_rdata, exp);
		end
		@(posedge clk);
	endtask : ext
	////////////////////////////////////////////////////////////////////////
	// Watchdog: far beyond the expected few hundred cycles
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		complete_run();
	end
	// Main sequence
	initial begin
		void'($urandom(32'hBE37));
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		rdc(deac_pkg::OFF_CTRL, 8'h00);
		// A full start inside the power-up window must not write
		wr(deac_pkg::OFF_CTRL, 8'h04);
		try_start(8'h55, 8'hAA, 1'b0, 8'h06);
		repeat (30) @(posedge clk);
		rdc(deac_pkg::OFF_FLAGS, 8'h00);
		rdc(deac_pkg::OFF_STATUS, 8'h01);
		for (int n = 0; n < 4; n++) begin
			a = (n == 0) ? 8'hFF : 8'($urandom);
			d = 8'($urandom);
			wr(deac_pkg::OFF_ADDR, a);
			wr(deac_pkg::OFF_DATA, d);
			wr(deac_pkg::OFF_CTRL, 8'h04); // Both selects clear
			try_start(8'h55, 8'hAA, 1'b0, 8'h06);
			rdc(deac_pkg::OFF_CTRL, 8'h06);
			// Busy: these three writes must all be ignored
			wr(deac_pkg::OFF_DATA, ~d);
			wr(deac_pkg::OFF_CTRL, 8'h00);
			wr(deac_pkg::OFF_ADDR, ~a);
			wait_idle();
			rdc(deac_pkg::OFF_CTRL, 8'h04);
			rdc(deac_pkg::OFF_ADDR, a);
			rdc(deac_pkg::OFF_FLAGS, 8'h10);
			wr(deac_pkg::OFF_FLAGS, 8'h00);
			rd_byte(a);
			wr(deac_pkg::OFF_ADDR, ~a);
			rdc(deac_pkg::OFF_DATA, d);
		end
		// Broken starts and permit set together with strobe
		for (int n = 0; n < 5; n++) begin
			wr(deac_pkg::OFF_DATA, ~d);
			wr(deac_pkg::OFF_CTRL, bpre[n]);
			try_start(bk1[n], bk2[n], bmid[n], 8'h06);
			rdc(deac_pkg::OFF_CTRL, 8'h0C);
			repeat (20) @(posedge clk);
			rdc(deac_pkg::OFF_FLAGS, 8'h00);
			rd_byte(a);
			rdc(deac_pkg::OFF_DATA, d);
		end
		// Read strobe with the program space selected leaves data alone
		wr(deac_pkg::OFF_DATA, ~d);
		wr(deac_pkg::OFF_CTRL, 8'h81);
		rdc(deac_pkg::OFF_DATA, ~d);
		wr(deac_pkg::OFF_DATA, d);
		// Completion with the interrupt enabled stays until cleared
		wr(deac_pkg::OFF_ENABLES, 8'hFF);
		rdc(deac_pkg::OFF_ENABLES, 8'hDF);
		wr(deac_pkg::OFF_CTRL, 8'h04);
		try_start(8'h55, 8'hAA, 1'b0, 8'h06);
		wait_idle();
		repeat (40) @(posedge clk);
		check(write_done_irq, 1'b1);
		rdc(deac_pkg::OFF_FLAGS, 8'h10);
		wr(deac_pkg::OFF_FLAGS, 8'h00);
		repeat (2) @(posedge clk);
		check(write_done_irq, 1'b0);
		// Unimplemented bits, key port and an unmapped address read zero
		wr(deac_pkg::OFF_CTRL, 8'h20);
		rdc(deac_pkg::OFF_CTRL, 8'h00);
		rdc(deac_pkg::OFF_KEY, 8'h00);
		rdc(5'h02, 8'h00);
		// Code protect: external access blocked, internal access kept
		code_protect <= 1'b1;
		repeat (8) @(posedge clk);
		rdc(deac_pkg::OFF_STATUS, 8'h03);
		ext(1'b0, a, 8'h00, 8'h00);
		ext(1'b1, a, ~d, 8'h00);
		repeat (20) @(posedge clk);
		rd_byte(a);
		rdc(deac_pkg::OFF_DATA, d);
		code_protect <= 1'b0;
		repeat (8) @(posedge clk);
		ext(1'b0, a, 8'h00, d);
		// Second reset in mid-run, inside a busy write: permit cleared and
		// the cut write shows as aborted
		wr(deac_pkg::OFF_CTRL, 8'h04);
		try_start(8'h55, 8'hAA, 1'b0, 8'h06);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		rdc(deac_pkg::OFF_CTRL, ctrl_exp(1'b1, 1'b0, 1'b0));
		complete_run();
	end
endmodule : test_data_eeprom_access_ctrl
